// >>> hw/avp_pkg.sv
// Package: register map, field layout and shared types of the analog value post-processor
package avp_pkg;
  localparam int AVP_CH = 2;
  localparam int AVP_DW = 16;
  localparam logic [15:0] AVP_SMAX = 16'h7FFF;
  localparam logic [15:0] AVP_SMIN = 16'h8000;
  localparam logic [15:0] AVP_ADC_TOP = 16'h7FFF;
  localparam logic [15:0] AVP_ADC_BOT = 16'h8000;
  localparam logic [15:0] AVP_UNI_FLOOR = 16'hFF00;
  localparam int AVP_USC_SHIFT = 16;
  localparam int AVP_VGAIN_SHIFT = 14;
  localparam logic [15:0] AVP_GAIN_ONE = 16'h4000;
  localparam logic [15:0] AVP_UGAIN_ONE = 16'hFFFF;
  localparam logic [15:0] AVP_CODEWORD = 16'hA5C3;
  // Channel block: byte stride between channels
  localparam logic [11:0] AVP_CH_STRIDE = 12'h040;
  localparam logic [5:0] AVP_R_CTRL = 6'h00;
  localparam logic [5:0] AVP_R_VOFF = 6'h04;
  localparam logic [5:0] AVP_R_VGAIN = 6'h08;
  localparam logic [5:0] AVP_R_UOFF = 6'h0C;
  localparam logic [5:0] AVP_R_UGAIN = 6'h10;
  localparam logic [5:0] AVP_R_CUOFF = 6'h14;
  localparam logic [5:0] AVP_R_CUGAIN = 6'h18;
  localparam logic [5:0] AVP_R_LIM1 = 6'h1C;
  localparam logic [5:0] AVP_R_LIM2 = 6'h20;
  localparam logic [5:0] AVP_R_RAW = 6'h24;
  localparam logic [5:0] AVP_R_VAL = 6'h28;
  localparam logic [5:0] AVP_R_STAT = 6'h2C;
  localparam logic [11:0] AVP_R_CODEWORD = 12'h100;
  // Control bit positions
  localparam int AVP_C_VEN = 0;
  localparam int AVP_C_UEN = 1;
  localparam int AVP_C_L1EN = 2;
  localparam int AVP_C_L2EN = 3;
  localparam int AVP_C_BIP = 4;
  localparam logic [4:0] AVP_CTRL_RST = 5'h11;
  localparam logic [15:0] AVP_STAT_RST = 16'h4000;
  // Status word positions
  localparam int AVP_S_UNDER = 0;
  localparam int AVP_S_OVER = 1;
  localparam int AVP_S_L1 = 2;
  localparam int AVP_S_L2 = 4;
  localparam int AVP_S_ERR = 6;
  localparam int AVP_S_STATE = 14;
  localparam int AVP_S_TOG = 15;
  localparam logic [1:0] AVP_LIM_OFF = 2'b00;
  localparam logic [1:0] AVP_LIM_ABOVE = 2'b01;
  localparam logic [1:0] AVP_LIM_BELOW = 2'b10;
  localparam logic [1:0] AVP_LIM_EQ = 2'b11;

  typedef struct packed {
    logic valid;
    logic [AVP_DW-1:0] data;
  } avp_sample_s;

  typedef struct packed {
    logic [AVP_DW-1:0] value;
    logic [AVP_DW-1:0] status;
  } avp_pdo_s;
endpackage

// >>> hw/avp_top.sv
// Analog value post-processor: correction, scaling, limits and status for two channels
// Behaviour
// - Raw sample stored per channel, uncorrected
// - Vendor correction: (raw minus offset) times gain
// - Vendor stage per-channel enable, offset, gain
// - Vendor words writable only with codeword set
// - User scaling: value times gain/65536 plus offset
// - Scaling off passes corrected value through
// - User scaling enable, offset, gain per channel
// - User calibration pair shares vendor enable
// - Two limits per channel, own result fields
// - Limits compare final processed value
// - Limit field 01 above, 10 below
// - Limit field 11 equal, 00 inactive
// - Underrange flag below measuring range
// - Overrange flag when range exceeded
// - Error flag on invalid value
// - Data state 0 valid, 1 invalid
// - Update toggle inverts on each refresh
// - Status presented every process cycle
// - Status word bit layout fixed
// - Overrange on converter top, clamp maximum
// - Underrange sets error, clamps low
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module avp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire avp_pkg::avp_sample_s sample_in [avp_pkg::AVP_CH],
  output avp_pkg::avp_pdo_s pdo_out [avp_pkg::AVP_CH]
);
  import avp_pkg::*;

  // ==========================================================
  // Functions
  // Clamp instead of wrap, so a large gain never flips the sign of a reading
  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    logic signed [47:0] hi;
    logic signed [47:0] lo;
    hi = 48'sh000000007FFF;
    lo = -48'sh000000008000;
    if (v > hi) begin
      sat16 = AVP_SMAX;
    end else if (v < lo) begin
      sat16 = AVP_SMIN;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // ==========================================================
  // APB decode
  wire apb_acc = psel & penable;
  // A write lands only on the edge that ends the access phase
  wire apb_wr = apb_acc & pwrite & pready & clk_en;
  wire apb_rd = apb_acc & ~pwrite;
  wire [5:0] reg_off = paddr[5:0];
  wire ch_sel = paddr[6];
  wire in_ch = (paddr[31:7] == 25'h0);
  wire is_cw = (paddr[31:0] == {20'h0, AVP_R_CODEWORD});
  wire off_ok = (reg_off <= AVP_R_STAT) && (reg_off[1:0] == 2'b00);
  wire hit = (in_ch && off_ok) || is_cw;
  wire wr_full = (pstrb[1:0] == 2'b11);
  wire [15:0] wdata = pwdata[15:0];

  logic [15:0] codeword;
  // Exact match only; any other value locks the vendor words again
  wire cw_set = (codeword == AVP_CODEWORD);

  logic [4:0] ctrl [AVP_CH];
  logic [15:0] voff [AVP_CH];
  logic [15:0] vgain [AVP_CH];
  logic [15:0] uoff [AVP_CH];
  logic [15:0] ugain [AVP_CH];
  logic [15:0] cuoff [AVP_CH];
  logic [15:0] cugain [AVP_CH];
  logic [15:0] lim1 [AVP_CH];
  logic [15:0] lim2 [AVP_CH];
  logic [15:0] raw [AVP_CH];
  logic [15:0] val [AVP_CH];
  logic [15:0] stat [AVP_CH];
  logic [15:0] rsel;

  // ==========================================================
  // Codeword register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      codeword <= 16'h0000;
    end else if (apb_wr && is_cw && wr_full) begin
      codeword <= wdata;
    end
  end

  // ==========================================================
  // Per-channel datapath
  genvar c;
  generate
    for (c = 0; c < AVP_CH; c++) begin : g_ch
      wire wsel = apb_wr && in_ch && (ch_sel == 1'(c)) && wr_full;
      wire vwr_ok = cw_set;
      wire ven = ctrl[c][AVP_C_VEN];
      wire uen = ctrl[c][AVP_C_UEN];
      wire bip = ctrl[c][AVP_C_BIP];
      // A sample offered while clk_en is low is lost, not delayed
      wire smp = sample_in[c].valid & clk_en;
      wire [15:0] x = sample_in[c].data;

      // ==========================================================
      // Parameter write strobes
      // Writes that do not cover the whole low half-word are dropped, never merged
      wire wr_ctrl = wsel && (reg_off == AVP_R_CTRL);
      wire wr_voff = wsel && vwr_ok && (reg_off == AVP_R_VOFF);
      wire wr_vgain = wsel && vwr_ok && (reg_off == AVP_R_VGAIN);
      wire wr_uoff = wsel && (reg_off == AVP_R_UOFF);
      wire wr_ugain = wsel && (reg_off == AVP_R_UGAIN);
      wire wr_cuoff = wsel && (reg_off == AVP_R_CUOFF);
      wire wr_cugain = wsel && (reg_off == AVP_R_CUGAIN);
      wire wr_lim1 = wsel && (reg_off == AVP_R_LIM1);
      wire wr_lim2 = wsel && (reg_off == AVP_R_LIM2);

      // ==========================================================
      // Vendor correction and user calibration
      // Gains are 2.14 fixed point; products stay wide and sat16 clamps the result of each stage
      wire signed [47:0] vdiff = 48'(signed'(x)) - 48'(signed'(voff[c]));
      wire signed [47:0] vprod = vdiff * 48'(signed'({1'b0, vgain[c]}));
      wire [15:0] yh_v = sat16(vprod >>> AVP_VGAIN_SHIFT);
      // User calibration shares the vendor enable
      wire signed [47:0] cdiff = 48'(signed'(yh_v)) - 48'(signed'(cuoff[c]));
      wire signed [47:0] cprod = cdiff * 48'(signed'({1'b0, cugain[c]}));
      wire [15:0] yh_c = sat16(cprod >>> AVP_VGAIN_SHIFT);
      wire [15:0] yh = ven ? yh_c : x;

      // ==========================================================
      // User scaling
      wire signed [47:0] uprod = 48'(signed'(yh)) * 48'(signed'({1'b0, ugain[c]}));
      wire signed [47:0] usum = (uprod >>> AVP_USC_SHIFT) + 48'(signed'(uoff[c]));
      wire [15:0] ya = uen ? sat16(usum) : yh;

      // ==========================================================
      // Range checks and clamping
      wire adc_top = (x == AVP_ADC_TOP);
      wire adc_bot = bip && (x == AVP_ADC_BOT);
      wire over = adc_top || (ya == AVP_SMAX && !adc_bot);
      wire under_bip = (signed'(ya) <= signed'(-16'sh7FFF));
      wire under_uni = (signed'(ya) < signed'(AVP_UNI_FLOOR));
      wire under_lim = bip ? under_bip : under_uni;
      wire under = !over && (adc_bot || under_lim);
      wire [15:0] floor_val = bip ? AVP_SMIN : 16'h0000;
      wire [15:0] fin = over ? AVP_SMAX : (under ? floor_val : ya);
      wire err = over | under;

      // ==========================================================
      // Limit comparison on the final value
      // Equal is reported only when neither strict compare holds
      wire l1_gt = (signed'(fin) > signed'(lim1[c]));
      wire l1_lt = (signed'(fin) < signed'(lim1[c]));
      wire l2_gt = (signed'(fin) > signed'(lim2[c]));
      wire l2_lt = (signed'(fin) < signed'(lim2[c]));
      wire [1:0] l1_cmp = l1_gt ? AVP_LIM_ABOVE : (l1_lt ? AVP_LIM_BELOW : AVP_LIM_EQ);
      wire [1:0] l1 = ctrl[c][AVP_C_L1EN] ? l1_cmp : AVP_LIM_OFF;
      wire [1:0] l2_cmp = l2_gt ? AVP_LIM_ABOVE : (l2_lt ? AVP_LIM_BELOW : AVP_LIM_EQ);
      wire [1:0] l2 = ctrl[c][AVP_C_L2EN] ? l2_cmp : AVP_LIM_OFF;

      // ==========================================================
      // Status word
      // Data state simply mirrors the error flag
      wire [15:0] next_stat;
      assign next_stat[AVP_S_UNDER] = under;
      assign next_stat[AVP_S_OVER] = over;
      assign next_stat[AVP_S_L1 +: 2] = l1;
      assign next_stat[AVP_S_L2 +: 2] = l2;
      assign next_stat[AVP_S_ERR] = err;
      assign next_stat[13:7] = 7'h00;
      assign next_stat[AVP_S_STATE] = err;
      assign next_stat[AVP_S_TOG] = ~stat[c][AVP_S_TOG];


      // ==========================================================
      // Parameter registers, one short process per word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl[c] <= AVP_CTRL_RST;
        end else if (wr_ctrl) begin
          ctrl[c] <= pwdata[4:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          voff[c] <= 16'h0000;
        end else if (wr_voff) begin
          voff[c] <= wdata;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          vgain[c] <= AVP_GAIN_ONE;
        end else if (wr_vgain) begin
          vgain[c] <= wdata;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          uoff[c] <= 16'h0000;
        end else if (wr_uoff) begin
          uoff[c] <= wdata;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ugain[c] <= AVP_UGAIN_ONE;
        end else if (wr_ugain) begin
          ugain[c] <= wdata;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cuoff[c] <= 16'h0000;
        end else if (wr_cuoff) begin
          cuoff[c] <= wdata;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cugain[c] <= AVP_GAIN_ONE;
        end else if (wr_cugain) begin
          cugain[c] <= wdata;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lim1[c] <= 16'h0000;
        end else if (wr_lim1) begin
          lim1[c] <= wdata;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lim2[c] <= 16'h0000;
        end else if (wr_lim2) begin
          lim2[c] <= wdata;
        end
      end

      // ==========================================================
      // Result registers
      // Value and status move together so the master never sees a torn pair
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          raw[c] <= 16'h0000;
          val[c] <= 16'h0000;
          stat[c] <= AVP_STAT_RST;
        end else if (smp) begin
          raw[c] <= x;
          val[c] <= fin;
          stat[c] <= next_stat;
        end
      end

      // ==========================================================
      // Process data output
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pdo_out[c] <= '{value: 16'h0000, status: AVP_STAT_RST};
        end else if (clk_en) begin
          pdo_out[c] <= '{value: val[c], status: stat[c]};
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read mux
  always_comb begin
    rsel = 16'h0000;
    if (is_cw) begin
      rsel = codeword;
    end else begin
      unique case (reg_off)
        AVP_R_CTRL: rsel = {11'h000, ctrl[ch_sel]};
        AVP_R_VOFF: rsel = voff[ch_sel];
        AVP_R_VGAIN: rsel = vgain[ch_sel];
        AVP_R_UOFF: rsel = uoff[ch_sel];
        AVP_R_UGAIN: rsel = ugain[ch_sel];
        AVP_R_CUOFF: rsel = cuoff[ch_sel];
        AVP_R_CUGAIN: rsel = cugain[ch_sel];
        AVP_R_LIM1: rsel = lim1[ch_sel];
        AVP_R_LIM2: rsel = lim2[ch_sel];
        AVP_R_RAW: rsel = raw[ch_sel];
        AVP_R_VAL: rsel = val[ch_sel];
        AVP_R_STAT: rsel = stat[ch_sel];
        default: rsel = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // APB answer: one wait state, pready registered
  // The first access cycle only arms the answer, so every transfer takes one wait state
  wire first_acc = apb_acc & ~pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= first_acc;
    end
  end

  // Unmapped addresses answer with an error and read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= first_acc & ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      prdata <= (apb_rd & first_acc & hit) ? {16'h0000, rsel} : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// >>> sim/analog_value_postprocess_test.sv
// Testbench of the analog value post-processor
`timescale 1ns/1ps
`default_nettype none
module analog_value_postprocess_test;
  import avp_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, rs;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [3:0] pstrb;
  logic [15:0] d, v;
  logic [15:0] lt [4] = '{16'h0110, 16'h0210, 16'h0060, 16'hFF10};
  avp_sample_s smp [AVP_CH];
  avp_pdo_s pdo [AVP_CH];
  logic [15:0] seen [AVP_CH];
  logic [15:0] ns [AVP_CH];
  logic tg [AVP_CH];
  int n_errors, num_checks;
  avp_top avp_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_in(smp), .pdo_out(pdo));
  avp_master_model avp_master_model_inst (.pclk(pclk), .presetn(presetn), .pdo_in(pdo),
    .seen(seen));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ======
  // Helpers
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ra(int c, logic [5:0] o);
    return 32'(c) * 32'(AVP_CH_STRIDE) + 32'(o);
  endfunction
  function automatic logic [1:0] lim(logic [15:0] x, logic [15:0] l);
    if ($signed(x) > $signed(l)) return AVP_LIM_ABOVE;
    if ($signed(x) < $signed(l)) return AVP_LIM_BELOW;
    return AVP_LIM_EQ;
  endfunction
  task automatic chk(logic [15:0] g, logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(logic w, logic [31:0] a, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rs = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_errors++;
  endtask
  // Flags f are {limit 2, limit 1, over, under}; data state follows error
  task automatic sc(int c, logic [15:0] x, logic [15:0] ev, logic [5:0] f);
    tg[c] = ~tg[c];
    ns[c] = ns[c] + 16'h0001;
    @(posedge pclk);
    smp[c] <= '{1'b1, x};
    @(posedge pclk);
    smp[c].valid <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk(pdo[c].value, ev);
    chk(pdo[c].status, {tg[c], |f[1:0], 7'h00, |f[1:0], f});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Whole sequence needs about 250 cycles; this allows about twenty times that
  initial begin
    #40000;
    n_errors++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    clk_en = 1'b1;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    smp = '{default: '0};
    tg = '{default: 1'b0};
    ns = '{default: 16'h0000};
    seed = 32'hE64D;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(pdo[0].status, 16'h4000);
    apb(0, ra(0, AVP_R_CTRL), 0);
    chk(rd[15:0], {11'h000, AVP_CTRL_RST});
    chk(rd[31:16], 16'h0000);
    apb(0, ra(1, AVP_R_VGAIN), 0);
    chk(rd[15:0], AVP_GAIN_ONE);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      d = seed[15:0];
      if (d inside {16'h7FFF, 16'h8000, 16'h8001}) d = 16'h1234;
      sc(i % 2, d, d, 6'h00);
    end
    apb(0, ra(1, AVP_R_RAW), 0);
    chk(rd[15:0], d);
    sc(0, AVP_ADC_TOP, AVP_SMAX, 6'h02);
    sc(1, AVP_ADC_BOT, AVP_SMIN, 6'h01);
    sc(0, AVP_ADC_BOT, AVP_SMIN, 6'h01);
    apb(1, ra(1, AVP_R_CUOFF), 32'h20);
    apb(1, ra(1, AVP_R_CUGAIN), 32'h2000);
    sc(1, 16'h0220, 16'h0100, 6'h00);
    apb(1, ra(1, AVP_R_CTRL), 32'h0);
    sc(1, 16'hFE00, 16'h0000, 6'h01);
    sc(1, 16'hFF00, 16'hFF00, 6'h00);
    pstrb <= 4'h1;
    apb(1, ra(1, AVP_R_LIM1), 32'h77);
    pstrb <= 4'hF;
    apb(0, ra(1, AVP_R_LIM1), 0);
    chk(rd[15:0], 16'h0000);
    $display("range test done");
    apb(1, ra(0, AVP_R_VOFF), 32'h10);
    apb(0, ra(0, AVP_R_VOFF), 0);
    chk(rd[15:0], 16'h0000);
    apb(1, 32'(AVP_R_CODEWORD), 32'(AVP_CODEWORD));
    apb(1, ra(0, AVP_R_VOFF), 32'h10);
    sc(0, 16'h0110, 16'h0100, 6'h00);
    apb(1, ra(0, AVP_R_CTRL), 32'h10);
    sc(0, 16'h0110, 16'h0110, 6'h00);
    apb(1, ra(0, AVP_R_CTRL), 32'h1D);
    apb(1, ra(0, AVP_R_LIM1), 32'h100);
    apb(1, ra(0, AVP_R_LIM2), 32'h200);
    for (int k = 0; k < 4; k++) begin
      v = lt[k] - 16'h0010;
      sc(0, lt[k], v, {lim(v, 16'h0200), lim(v, 16'h0100), 2'b00});
    end
    $display("limit test done");
    apb(1, ra(0, AVP_R_CTRL), 32'h13);
    apb(1, ra(0, AVP_R_UGAIN), 32'h8000);
    apb(1, ra(0, AVP_R_UOFF), 32'h5);
    sc(0, 16'h0210, 16'h0105, 6'h00);
    apb(0, 32'h200, 0);
    chk({15'h0000, rs}, 16'h0001);
    chk(rd[15:0], 16'h0000);
    @(posedge pclk);
    clk_en <= 1'b0;
    smp[1] <= '{1'b1, 16'h0333};
    @(posedge pclk);
    smp[1].valid <= 1'b0;
    clk_en <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk(seen[0], ns[0]);
    chk(seen[1], ns[1]);
    $display("scaling and freeze test done");
    close_out();
  end
endmodule
`default_nettype wire

// >>> sim/avp_master_model.sv
// Cyclic master model: reads process data every cycle
`timescale 1ns/1ps
`default_nettype none
module avp_master_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire avp_pkg::avp_pdo_s pdo_in [avp_pkg::AVP_CH],
  output logic [15:0] seen [avp_pkg::AVP_CH]
);
  import avp_pkg::*;
  logic [AVP_CH-1:0] last;
  // ======
  // Read every cycle, so no toggle edge is ever missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= '0;
      seen <= '{default: 16'h0000};
    end else begin
      for (int i = 0; i < AVP_CH; i++) begin
        last[i] <= pdo_in[i].status[AVP_S_TOG];
        if (last[i] != pdo_in[i].status[AVP_S_TOG]) begin
          seen[i] <= seen[i] + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/avp_top_monitor.sv
// Checker of the post-processor outputs
`timescale 1ns/1ps
`default_nettype none
module avp_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic pready,
  input wire logic pslverr,
  input wire avp_pkg::avp_sample_s sample_in [avp_pkg::AVP_CH],
  input wire avp_pkg::avp_pdo_s pdo_out [avp_pkg::AVP_CH]
);
  import avp_pkg::*;
  logic [15:0] s0, s1, v0;
  logic k0, k1;
  assign s0 = pdo_out[0].status;
  assign s1 = pdo_out[1].status;
  assign v0 = pdo_out[0].value;
  assign k0 = sample_in[0].valid & clk_en;
  assign k1 = sample_in[1].valid & clk_en;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ======
  // Outputs lag a taken sample by two edges
  AST_TOG0: assert property (k0 ##1 clk_en |=> $changed(s0[15]))
    else $error("ch0 toggle kept");
  AST_TOG1: assert property (k1 ##1 clk_en |=> $changed(s1[15]))
    else $error("ch1 toggle kept");
  AST_ADCTOP: assert property (k0 && sample_in[0].data == AVP_ADC_TOP ##1 clk_en |=> s0[1])
    else $error("no overrange on top");
  AST_ADCBOT: assert property (k0 && sample_in[0].data == AVP_ADC_BOT ##1 clk_en |=> s0[0])
    else $error("no underrange on bottom");
  AST_ERR: assert property (s0[0] || s0[1] |-> s0[6])
    else $error("range fault without error");
  AST_STATE: assert property (s0[6] |-> s0[14])
    else $error("error but state valid");
  AST_OVCLAMP: assert property (s0[1] |-> v0 == AVP_SMAX)
    else $error("overrange not clamped");
  AST_UNCLAMP: assert property (s0[0] |-> v0 == AVP_SMIN || v0 == 16'h0000)
    else $error("underrange not clamped");
  AST_PR1: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_SERR: assert property (pslverr |-> pready)
    else $error("slave error outside ready");
  cover property (k0 ##2 k1);
  cover property (s0[1]);
  cover property (pslverr);
endmodule
bind avp_top avp_top_monitor avp_top_monitor_inst (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
  .pdo_out(pdo_out));
`default_nettype wire
